/* File: rtl/spx_port.sv */
// serial peripheral port: master or slave, four clock modes, 3/4/5 pins
// assumes static configuration ports, changed only while idle; in slave
// mode the serial clock pin clocks the link-side shifter directly
`timescale 1ns/1ns

// Operation
// [RQ1] As master the port starts transfers and drives the serial clock; as slave it follows the external clock.
// [RQ2] A word is loaded for transmit before a transfer and the received word is offered once the transfer ends.
// [RQ3] Clock polarity and phase are selectable, giving four clocking modes.
// [RQ4] The port works with three pins, and with four or five pins adding slave select and/or ready handshake.
// [RQ5] A slave using slave select shifts and drives its output only while the select input is low.
// [RQ6] The slave handshake output is optional and can be push-pull or open-drain.
// [RQ7] In four-pin handshake mode the slave asserts ready only while its transmit buffer is full.
// [RQ8] In five-pin mode the slave asserts ready only while its buffer is full and it is selected.
// [RQ9] A master with the handshake enabled waits for ready before starting the next transfer.
// [RQ10] A deselected slave releases its output line to high impedance.
module spx_port #(
  parameter int unsigned WORD_W = spx_pkg::WORD_W_DEF,
  parameter int unsigned SCK_HALF = spx_pkg::SCK_HALF_DEF,
  parameter int unsigned FIFO_DEPTH = spx_pkg::FIFO_DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic master_mode,
  input wire logic clk_pol,
  input wire logic clk_pha,
  input wire logic [1:0] pin_mode,
  input wire logic ena_open_drain,
  input wire logic [WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [WORD_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic busy,
  output logic rx_overrun,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic slave_in_master_out_pin_i,
  output logic slave_in_master_out_pin_o,
  output logic slave_in_master_out_pin_oe,
  input wire logic slave_out_master_in_pin_i,
  output logic slave_out_master_in_pin_o,
  output logic slave_out_master_in_pin_oe,
  input wire logic slave_select_pin_n_i,
  output logic slave_select_pin_n_o,
  output logic slave_select_pin_n_oe,
  input wire logic ready_handshake_pin_n_i,
  output logic ready_handshake_pin_n_o,
  output logic ready_handshake_pin_n_oe
);
  localparam int unsigned BW = $clog2(WORD_W + 1);
  localparam int unsigned EW = $clog2(2 * WORD_W + 1);
  localparam int unsigned DW = $clog2(SCK_HALF + 1);

  initial begin
    if (WORD_W < 2) begin
      $error("spx_port word width must be at least two");
    end
    if (SCK_HALF < spx_pkg::SCK_HALF_MIN ||
        SCK_HALF < spx_pkg::SCK_HALF_SYNC) begin
      $error("spx_port serial clock half period too short");
    end
  end

  // ---------------------------------------------------------------
  // system-domain state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL} spx_state_t;

  typedef struct packed {
    spx_state_t st;
    logic [DW-1:0] div;
    logic [EW-1:0] edges;
    logic [BW-1:0] bits;
    logic sck;
    logic mosi;
    logic [WORD_W-1:0] txsh;
    logic [WORD_W-1:0] rxsh;
    logic [WORD_W-1:0] tx_word;
    logic tx_full;
    logic sel_n;
    logic push_v;
    logic [WORD_W-1:0] push_d;
    logic overrun;
    logic miso_s1;
    logic miso_s2;
    logic ena_s1;
    logic ena_s2;
    logic cs_s1;
    logic cs_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic ena_o;
    logic ena_oe;
    logic somi_oe;
  } spx_sys_t;

  spx_sys_t s_q;
  spx_sys_t s_d;

  logic use_cs;
  logic use_ena;
  logic lead;
  logic samp_edge;
  logic ena_assert;
  logic done_evt;

  spx_stream_if #(.WIDTH(WORD_W)) push_if ();
  spx_stream_if #(.WIDTH(WORD_W)) pop_if ();

  // pin option decode [RQ4]
  assign use_cs = (pin_mode == spx_pkg::SPX_PINS_4_CS) ||
                  (pin_mode == spx_pkg::SPX_PINS_5);
  assign use_ena = (pin_mode == spx_pkg::SPX_PINS_4_ENA) ||
                   (pin_mode == spx_pkg::SPX_PINS_5);

  // ---------------------------------------------------------------
  // link domain: slave shifter on the external serial clock
  // ---------------------------------------------------------------
  // sampling edge is rising for modes 0 and 3, falling for 1 and 2
  logic samp_clk;
  logic frame_clr;
  logic link_rst;
  logic [BW-1:0] lk_cnt_q;
  logic [WORD_W-1:0] lk_rx_q;
  logic [WORD_W-1:0] lk_word_q;
  logic lk_tgl_q;
  logic [WORD_W-1:0] lk_sh_q;
  logic lk_out_q;

  assign samp_clk = serial_clock_pin_i ^ clk_pol ^ clk_pha; // [RQ3]
  // the serial clock stops between frames, so the select pin itself
  // ends a frame; without it the bit count runs word to word [RQ5]
  assign frame_clr = !master_mode && use_cs && slave_select_pin_n_i;
  assign link_rst = !resetn || master_mode;

  // bit counter and receive shift on the sampling edge [RQ1]
  always_ff @(posedge samp_clk or posedge link_rst or posedge frame_clr)
  begin
    if (link_rst || frame_clr) begin
      lk_cnt_q <= '0;
      lk_rx_q <= '0;
    end else if (lk_cnt_q == BW'(WORD_W - 1)) begin
      lk_cnt_q <= '0;
      lk_rx_q <= '0;
    end else begin
      lk_cnt_q <= lk_cnt_q + 1'b1;
      lk_rx_q <= {lk_rx_q[WORD_W-2:0], slave_in_master_out_pin_i};
    end
  end

  // completed word and its toggle survive deselection [RQ2]
  always_ff @(posedge samp_clk or posedge link_rst) begin
    if (link_rst) begin
      lk_word_q <= '0;
      lk_tgl_q <= 1'b0;
    end else if (lk_cnt_q == BW'(WORD_W - 1) &&
                 !(use_cs && slave_select_pin_n_i)) begin
      lk_word_q <= {lk_rx_q[WORD_W-2:0], slave_in_master_out_pin_i};
      lk_tgl_q <= !lk_tgl_q;
    end
  end

  // output shift on the opposite edge; at count zero the next word is
  // taken, which for phase 0 preloads the first bit of the next frame.
  // tx_word is held stable by tx_full until the done toggle is seen
  always_ff @(negedge samp_clk or posedge link_rst) begin
    if (link_rst) begin
      lk_sh_q <= '0;
      lk_out_q <= 1'b0;
    end else if (lk_cnt_q == '0) begin
      lk_out_q <= s_q.tx_word[WORD_W-1]; // [RQ2]
      lk_sh_q <= {s_q.tx_word[WORD_W-2:0], 1'b0};
    end else begin
      lk_out_q <= lk_sh_q[WORD_W-1];
      lk_sh_q <= {lk_sh_q[WORD_W-2:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // system domain next state
  // ---------------------------------------------------------------
  assign lead = !s_q.edges[0];
  assign samp_edge = (lead != clk_pha); // [RQ3]
  assign done_evt = s_q.tg_s2 ^ s_q.tg_s3;
  // slave ready: buffer full, and selected in five-pin mode [RQ7] [RQ8]
  assign ena_assert = s_q.tx_full &&
                      ((pin_mode != spx_pkg::SPX_PINS_5) || !s_q.cs_s2);

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for pins and the done toggle
    s_d.miso_s1 = slave_out_master_in_pin_i;
    s_d.miso_s2 = s_q.miso_s1;
    s_d.ena_s1 = ready_handshake_pin_n_i;
    s_d.ena_s2 = s_q.ena_s1;
    s_d.cs_s1 = slave_select_pin_n_i;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.tg_s1 = lk_tgl_q;
    s_d.tg_s2 = s_q.tg_s1;
    s_d.tg_s3 = s_q.tg_s2;
    // fifo accepted the pending word
    if (s_q.push_v && push_if.ready) begin
      s_d.push_v = 1'b0;
    end
    // user loads the single-word transmit buffer [RQ2]
    if (tx_valid && !s_q.tx_full) begin
      s_d.tx_word = tx_data;
      s_d.tx_full = 1'b1;
    end
    // slave word done: offer it, free the buffer; a word still
    // waiting for the fifo is lost since a slave cannot stall
    if (!master_mode && done_evt) begin
      s_d.push_d = lk_word_q; // [RQ2]
      s_d.push_v = 1'b1;
      s_d.tx_full = 1'b0;
      if (s_q.push_v && !push_if.ready) begin
        s_d.overrun = 1'b1;
      end
    end
    // slave handshake pin drive, push-pull or open-drain [RQ6]
    if (!master_mode && use_ena) begin
      s_d.ena_o = ena_open_drain ? 1'b0 : !ena_assert;
      s_d.ena_oe = ena_open_drain ? ena_assert : 1'b1;
    end else begin
      s_d.ena_o = 1'b1;
      s_d.ena_oe = 1'b0;
    end
    // slave output released while deselected [RQ5] [RQ10]
    s_d.somi_oe = !master_mode && (!use_cs || !s_q.cs_s2);

    // master sequencer [RQ1]
    case (s_q.st)
      ST_IDLE: begin
        s_d.sck = clk_pol;
        s_d.sel_n = 1'b1;
        // waits for a word, room for the answer and the slave's ready
        if (master_mode && s_q.tx_full && !s_q.push_v &&
            (!use_ena || !s_q.ena_s2)) begin // [RQ9]
          s_d.st = ST_RUN;
          s_d.tx_full = 1'b0;
          s_d.sel_n = !use_cs;
          s_d.div = '0;
          s_d.edges = '0;
          s_d.bits = '0;
          s_d.rxsh = '0;
          s_d.txsh = s_q.tx_word; // [RQ2]
          if (!clk_pha) begin
            s_d.mosi = s_q.tx_word[WORD_W-1];
            s_d.txsh = {s_q.tx_word[WORD_W-2:0], 1'b0};
          end
        end
      end
      ST_RUN: begin
        s_d.div = s_q.div + 1'b1;
        if (s_q.div == DW'(SCK_HALF - 1)) begin
          s_d.div = '0;
          s_d.sck = !s_q.sck;
          s_d.edges = s_q.edges + 1'b1;
          if (samp_edge) begin
            s_d.rxsh = {s_q.rxsh[WORD_W-2:0], s_q.miso_s2};
            s_d.bits = s_q.bits + 1'b1;
          end else begin
            s_d.mosi = s_q.txsh[WORD_W-1];
            s_d.txsh = {s_q.txsh[WORD_W-2:0], 1'b0};
          end
          if (s_q.edges == EW'(2 * WORD_W - 1)) begin
            s_d.st = ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        // hold select for one more half period after the last edge
        s_d.div = s_q.div + 1'b1;
        if (s_q.div == DW'(SCK_HALF - 1)) begin
          s_d.st = ST_IDLE;
          s_d.sel_n = 1'b1;
          s_d.push_d = s_q.rxsh; // [RQ2]
          s_d.push_v = 1'b1;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // system-domain register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.sel_n <= 1'b1;
      s_q.ena_o <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // receive fifo
  // ---------------------------------------------------------------
  assign push_if.valid = s_q.push_v;
  assign push_if.data = s_q.push_d;
  assign pop_if.ready = rx_ready;

  spx_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wr(push_if),
    .rd(pop_if)
  );

  // ---------------------------------------------------------------
  // outputs from flops, except the clock, mosi and select pin enables
  // ---------------------------------------------------------------
  assign tx_ready = !s_q.tx_full;
  assign rx_data = pop_if.data;
  assign rx_valid = pop_if.valid;
  assign busy = (s_q.st != ST_IDLE);
  assign rx_overrun = s_q.overrun;
  assign serial_clock_pin_o = s_q.sck;
  assign serial_clock_pin_oe = master_mode; // [RQ1]
  assign slave_in_master_out_pin_o = s_q.mosi;
  assign slave_in_master_out_pin_oe = master_mode;
  assign slave_out_master_in_pin_o = lk_out_q;
  assign slave_out_master_in_pin_oe = s_q.somi_oe; // [RQ10]
  assign slave_select_pin_n_o = s_q.sel_n;
  assign slave_select_pin_n_oe = master_mode && use_cs;
  assign ready_handshake_pin_n_o = s_q.ena_o;
  assign ready_handshake_pin_n_oe = s_q.ena_oe; // [RQ6]
endmodule

/* File: rtl/spx_pkg.sv */
// package for the serial peripheral port: widths, pin modes, timing
// assumes a 20 MHz system clock and one port instance per package user
package spx_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned SCK_MAX_HZ = 10_000_000;
  // least half period of the serial clock, rounded up to whole cycles
  localparam int unsigned SCK_HALF_MIN =
    (SYS_CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
  // miso passes two sync flops, so a half period needs three cycles
  localparam int unsigned SCK_HALF_SYNC = 3;
  localparam int unsigned SCK_HALF_DEF = 4;

  // ---------------------------------------------------------------
  // data and buffering
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W_DEF = 16;
  localparam int unsigned FIFO_DEPTH_DEF = 32;

  // ---------------------------------------------------------------
  // pin options
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SPX_PINS_3     = 2'h0,
    SPX_PINS_4_CS  = 2'h1,
    SPX_PINS_4_ENA = 2'h2,
    SPX_PINS_5     = 2'h3
  } spx_pins_t;

endpackage

/* File: rtl/spx_stream_if.sv */
// valid/ready word stream between the port core and its fifo
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface spx_stream_if #(
  parameter int unsigned WIDTH = 16
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/spx_fifo.sv */
// word fifo with a registered read stage
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module spx_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  spx_stream_if.snk wr,
  spx_stream_if.src rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("spx_fifo depth must be a power of two of at least two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic out_v_q;
  logic [WIDTH-1:0] out_d_q;
  logic push;
  logic pop;

  // -------------------------------------------------------------
  // handshakes: read stage refills whenever it is empty or drained
  // -------------------------------------------------------------
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign push = wr.valid && wr.ready;
  assign pop = (cnt_q != '0) && (!out_v_q || rd.ready);
  assign rd.valid = out_v_q;
  assign rd.data = out_d_q;

  // storage has no reset; only pointers and flags need one
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  // pointers, level and read register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      out_v_q <= 1'b0;
      out_d_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
        out_d_q <= mem[rp_q];
        out_v_q <= 1'b1;
      end else if (rd.ready) begin
        out_v_q <= 1'b0;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: dv/spx_chk.sv */
// checker of pin drivers, handshake and serial clock of spx_port
// assumes a bind to spx_port with SCK_HALF of 4
`timescale 1ns/1ns
module spx_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic master_mode,
  input wire logic clk_pol,
  input wire logic [1:0] pin_mode,
  input wire logic ena_open_drain,
  input wire logic tx_ready,
  input wire logic busy,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic slave_out_master_in_pin_oe,
  input wire logic slave_select_pin_n_i,
  input wire logic slave_select_pin_n_o,
  input wire logic ready_handshake_pin_n_i,
  input wire logic ready_handshake_pin_n_o,
  input wire logic ready_handshake_pin_n_oe
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ready counts as shown when the pin is driven low
  wire rdy_on = ready_handshake_pin_n_oe && !ready_handshake_pin_n_o;
  wire slv = !master_mode;
  // only the master drives the serial clock
  AST_SCK_OE: assert property (serial_clock_pin_oe == master_mode)
    else $error("clock pin enable wrong");
  AST_SEL_BUSY: assert property (master_mode && !slave_select_pin_n_o |-> busy)
    else $error("select low while idle");
  // deselected slave keeps off the shared line; sync lag allowed
  AST_MISO_DESEL: assert property ((slv && pin_mode[0] && slave_select_pin_n_i)[*4] |-> !slave_out_master_in_pin_oe)
    else $error("output driven while deselected");
  AST_RDY_FULL: assert property ((slv && pin_mode[1] && tx_ready)[*2] |-> !rdy_on)
    else $error("ready with empty buffer");
  AST_RDY_SEL: assert property ((slv && pin_mode == 2'h3 && slave_select_pin_n_i)[*4] |-> !rdy_on)
    else $error("ready while deselected");
  // drive mode takes one cycle to follow a change of ena_open_drain
  AST_RDY_OD: assert property ((slv && ena_open_drain)[*2] ##0 ready_handshake_pin_n_oe |-> !ready_handshake_pin_n_o)
    else $error("open-drain ready drove high");
  AST_RDY_PP: assert property ((slv && !ena_open_drain && pin_mode[1])[*2] |-> ready_handshake_pin_n_oe)
    else $error("push-pull ready not driven");
  // clock rests at its polarity and keeps whole half periods
  AST_IDLE_SCK: assert property ((master_mode && !busy && $stable(clk_pol))[*3] |-> serial_clock_pin_o == clk_pol)
    else $error("idle clock level wrong");
  AST_SCK_HALF: assert property (busy && $changed(serial_clock_pin_o) |=> $stable(serial_clock_pin_o)[*3])
    else $error("half period too short");
  AST_ENA_HOLD: assert property ((master_mode && pin_mode[1] && ready_handshake_pin_n_i && !busy)[*4] |=> !busy)
    else $error("start without ready");
endmodule

/* File: dv/spx_far_slave.sv */
// far-side slave model for the port in master role
// assumes the port's busy marks the frames that it clocks
`timescale 1ns/1ns
module spx_far_slave (
  input wire logic sck,
  input wire logic mosi,
  input wire logic act,
  input wire logic pol,
  input wire logic pha,
  input wire logic rdy,
  output logic miso,
  output logic rdy_n
);
  // ------------------------------------------------------------
  // shifter
  // ------------------------------------------------------------
  logic [15:0] sr;
  logic [15:0] rxq[$];
  logic [15:0] cur;
  logic ps = 1'b0;
  int cnt = 0;
  int idx = 0;
  int k = 0;
  // frame k answers with a word fixed by its index
  assign cur = 16'h5A3C ^ 16'(k * 16'h0F1D);
  // outside frames the line shows the inverse, never a stale bit
  assign miso = act ? cur[15-idx] : !cur[15-idx];
  assign rdy_n = !rdy;
  // edges outside a frame are ignored: idle clock may move with pol
  always @(sck or act) begin
    if (!act) begin
      cnt = 0;
      idx = 0;
    end else if (sck !== ps) begin
      if ((sck != pol) ^ pha) begin
        sr = {sr[14:0], mosi};
        cnt++;
        if (cnt == 16) begin
          rxq.push_back(sr);
          k++;
        end
      end else if (cnt < 16) begin
        idx = cnt;
      end
    end
    ps = sck;
  end
endmodule

/* File: dv/tb.sv */
// testbench of spx_port: master against a model, slave from the bench
// assumes spx_chk and spx_far_slave are compiled before it
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic master_mode = 1'b1;
  logic clk_pol = 1'b0;
  logic clk_pha = 1'b0;
  logic [1:0] pin_mode = 2'h0;
  logic ena_open_drain = 1'b0;
  logic [15:0] tx_data = 16'h0;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic [15:0] rx_data;
  logic rx_ovr;
  logic tx_ready, rx_valid, busy, sck_o, sck_oe, mosi_o, mosi_oe;
  logic miso_o, miso_oe, ss_o, ss_oe, rdy_o, rdy_oe, p_miso, p_rdy_n;
  logic sck_t = 1'b0;
  logic mosi_t = 1'b0;
  logic ss_t = 1'b1;
  logic rdy = 1'b1;
  logic [15:0] sq[$];
  int failures = 0;
  int samples_checked = 0;
  int nt = 0;
  // each pin settles to whoever enables it; ready has a pull-up in slave role, the model drives it in master role
  wire sck_w = sck_oe ? sck_o : sck_t;
  wire mosi_w = mosi_oe ? mosi_o : mosi_t;
  wire miso_w = miso_oe ? miso_o : p_miso;
  wire ss_w = ss_oe ? ss_o : ss_t;
  wire rdy_w = rdy_oe ? rdy_o : (master_mode ? p_rdy_n : 1'b1);

  spx_port #(.WORD_W(16), .SCK_HALF(4), .FIFO_DEPTH(32)) dut (
    .sys_clk, .resetn, .master_mode, .clk_pol, .clk_pha, .pin_mode,
    .ena_open_drain, .tx_data, .tx_valid, .tx_ready, .rx_data,
    .rx_valid, .rx_ready, .busy, .rx_overrun(rx_ovr),
    .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .slave_in_master_out_pin_i(mosi_w),
    .slave_in_master_out_pin_o(mosi_o),
    .slave_in_master_out_pin_oe(mosi_oe),
    .slave_out_master_in_pin_i(miso_w),
    .slave_out_master_in_pin_o(miso_o),
    .slave_out_master_in_pin_oe(miso_oe), .slave_select_pin_n_i(ss_w),
    .slave_select_pin_n_o(ss_o), .slave_select_pin_n_oe(ss_oe),
    .ready_handshake_pin_n_i(rdy_w), .ready_handshake_pin_n_o(rdy_o),
    .ready_handshake_pin_n_oe(rdy_oe));
  spx_far_slave p (.sck(sck_w), .mosi(mosi_w), .act(busy),
    .pol(clk_pol), .pha(clk_pha), .rdy, .miso(p_miso), .rdy_n(p_rdy_n));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #25 sys_clk = ~sys_clk;
  function automatic logic [15:0] pexp(input int n);
    return 16'h5A3C ^ 16'(n * 16'h0F1D);
  endfunction
  task automatic chk(input bit c, input string m);
    samples_checked++;
    if (!c) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // offer a word; gives up after 400 cycles, which counts as refused
  task automatic send(input logic [15:0] w, output bit ok);
    int n;
    n = 0;
    @(negedge sys_clk);
    tx_data = w;
    tx_valid = 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 400);
    ok = (tx_ready === 1'b1);
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask
  task automatic get(output logic [15:0] w, output bit ok);
    int n;
    n = 0;
    @(negedge sys_clk);
    rx_ready = 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rx_valid !== 1'b1 && n < 400);
    ok = (rx_valid === 1'b1);
    w = rx_data;
    @(negedge sys_clk);
    rx_ready = 1'b0;
  endtask
  // one master transfer; with handshake the slave is late on purpose
  task automatic xfer();
    logic [15:0] v, w;
    bit ok;
    v = 16'($urandom);
    rdy = !pin_mode[1];
    repeat (3) @(negedge sys_clk);
    send(v, ok);
    if (pin_mode[1]) begin
      repeat (20) @(negedge sys_clk);
      chk(busy === 1'b0, "started before ready");
      rdy = 1'b1;
    end
    get(w, ok);
    chk(ok && w === pexp(nt), "word from slave");
    chk(p.rxq[nt] === v, "word to slave");
    nt++;
  endtask
  // link clock runs only inside a frame, data set before each rise
  task automatic frame(input logic [15:0] w);
    #7;
    for (int b = 15; b >= 0; b--) begin
      mosi_t = w[b];
      #15 sck_t = 1'b1;
      #15 sck_t = 1'b0;
    end
    mosi_t = !w[0];
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [15:0] v, w;
    bit ok;
    int base;
    void'($urandom(32'hAE635B30));
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    // every clock mode, every pin option first, then random options
    for (int m = 0; m < 12; m++) begin
      @(negedge sys_clk);
      {clk_pha, clk_pol} = 2'(m);
      pin_mode = (m < 4) ? 2'(m) : 2'($urandom);
      xfer();
    end
    $display("test modes done");
    // reader stalls until the fifo refuses, then drains in order
    @(negedge sys_clk);
    pin_mode = 2'h1;
    base = nt;
    ok = 1'b1;
    for (int i = 0; i < 40 && ok; i++) begin
      v = (i == 0) ? 16'h8001 : 16'($urandom);
      send(v, ok);
      if (ok) sq.push_back(v);
    end
    ok = 1'b1;
    for (int j = 0; ok; j++) begin
      get(w, ok);
      if (ok) begin
        chk(w === pexp(nt), "fifo order");
        chk(p.rxq[nt] === sq[j], "fifo word out");
        nt++;
      end
    end
    chk(nt - base == sq.size() && sq.size() >= 32, "fifo count");
    $display("test fifo done");
    // slave role: push-pull ready with four pins, then open-drain ready with five pins
    master_mode = 1'b0;
    // bench link clock rests low, so pick a mode whose idle level is low
    {clk_pha, clk_pol} = 2'h0;
    pin_mode = 2'h2;
    repeat (4) @(negedge sys_clk);
    pin_mode = 2'h3;
    ena_open_drain = 1'b1;
    send(16'($urandom), ok);
    repeat (6) @(negedge sys_clk);
    chk(rdy_w === 1'b1, "ready while deselected");
    for (int s = 0; s < 2; s++) begin
      v = 16'($urandom);
      ss_t = (s == 0);
      repeat (6) @(negedge sys_clk);
      if (s == 1) chk(rdy_w === 1'b0, "no ready when full");
      frame(v);
      @(negedge sys_clk);
      ss_t = 1'b1;
      repeat (12) @(negedge sys_clk);
      if (s == 0) chk(rx_valid === 1'b0, "shifted deselected");
    end
    get(w, ok);
    chk(ok && w === v, "slave word in");
    chk(tx_ready === 1'b1, "buffer not freed");
    chk(rx_ovr === 1'b0, "slave word lost");
    $display("test slave done");
    print_verdict();
  end
  // hang guard, about five times the planned run
  initial begin
    #(40000 * 50);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule

bind spx_port spx_chk chk_i (.sys_clk, .resetn, .master_mode, .clk_pol,
  .pin_mode, .ena_open_drain, .tx_ready, .busy, .serial_clock_pin_o,
  .serial_clock_pin_oe, .slave_out_master_in_pin_oe,
  .slave_select_pin_n_i, .slave_select_pin_n_o, .ready_handshake_pin_n_i,
  .ready_handshake_pin_n_o, .ready_handshake_pin_n_oe);
